//--- pblc_ctrl.sv
// self-test and loopback control register with error counter and interrupts
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "pblc_regs.svh"

// Summary of operation
// - single mode: error counter saturates at maximum and stops counting
// - continuous mode: counter pulses at maximum and restarts from zero
// - config 0 disables generator and checker; 2 enables checker only
// - config 3 enables both, generator sends packets continuously
// - lock bit reads 1 while checker is locked to stream
// - sync-loss bit set by hardware when checker loses sync
// - generator status bit reads 1 while generator is active
// - power bit reads 0 in active sleep, 1 otherwise; resets to 1
// - transmit-in-loopback at 100 Mbps sends MAC data to line too
// - loopback select 1 is PCS input (10 Mbps), 2 PCS output
// - select 4 is digital loopback, 100 Mbps, extra writes needed
// - select 8 is analog loopback, 0x10 is reverse loopback
module pblc_ctrl #(
  parameter int ERR_W = `PBLC_ERR_CNT_W
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // register port
  input  wire logic [4:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [15:0]       o_rdata,
  // datapath status
  input  wire logic              i_chk_err,
  input  wire logic              i_chk_locked,
  input  wire logic              i_gen_active,
  input  wire logic              i_active_sleep,
  input  wire logic              i_speed_100,
  input  wire logic              i_mii_loopback,
  // datapath control
  output logic                   o_gen_en,
  output logic                   o_gen_continuous,
  output logic                   o_chk_en,
  output logic                   o_tx_in_loop,
  output logic      [4:0]        o_lb_sel,
  output logic      [ERR_W-1:0]  o_err_count,
  output logic                   o_err_wrap,
  output logic                   o_irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic             cnt_mode_reg;
  logic [1:0]       cfg_reg;
  logic             tx_loop_reg;
  logic [4:0]       lb_reg;
  logic             sync_loss_reg;
  logic             lock_reg;
  logic             gen_act_reg;
  logic             pwr_norm_reg;
  logic [ERR_W-1:0] err_cnt_reg;
  logic [ERR_W-1:0] err_cnt_next;
  logic             wrap_next;
  logic [`PBLC_IRQ_W-1:0] irq_stat_reg;
  logic [`PBLC_IRQ_W-1:0] irq_mask_reg;
  logic             lock_s1, lock_s2, gen_s1, gen_s2, slp_s1, slp_s2, err_s1, err_s2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = `PBLC_CTRL_RESET;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic pblc_hit(input logic [4:0] addr, input logic [4:0] off);
    return addr == off;
  endfunction
  wire logic sel_ctrl = pblc_hit(i_addr, `PBLC_OFF_CTRL);
  wire logic sel_stat = pblc_hit(i_addr, `PBLC_OFF_IRQ_STAT);
  wire logic sel_mask = pblc_hit(i_addr, `PBLC_OFF_IRQ_MASK);
  wire logic wr_ctrl  = i_wr && sel_ctrl;
  wire logic wr_stat  = i_wr && sel_stat;
  wire logic wr_mask  = i_wr && sel_mask;
  wire pblc_pkg::pblc_cfg_t cfg = pblc_pkg::pblc_cfg_t'(cfg_reg);
  wire logic chk_on   = (cfg == pblc_pkg::PBLC_CFG_CHK_ONLY) ||
                        (cfg == pblc_pkg::PBLC_CFG_GEN_CHK);
  wire logic gen_on   = (cfg == pblc_pkg::PBLC_CFG_GEN_SINGLE) ||
                        (cfg == pblc_pkg::PBLC_CFG_GEN_CHK);
  wire logic gen_cont = (cfg == pblc_pkg::PBLC_CFG_GEN_CHK);
  wire logic cnt_max  = (err_cnt_reg == {ERR_W{1'b1}});
  wire logic count_ev = chk_on && err_s2;
  wire logic lock_fall = lock_reg && !lock_s2 && chk_on;
  wire logic lb_legal = (lb_reg == pblc_pkg::PBLC_LB_PCS_IN) ||
                        (lb_reg == pblc_pkg::PBLC_LB_PCS_OUT) ||
                        (lb_reg == pblc_pkg::PBLC_LB_DIGITAL) ||
                        (lb_reg == pblc_pkg::PBLC_LB_ANALOG) ||
                        (lb_reg == pblc_pkg::PBLC_LB_REVERSE);
  wire logic [4:0] lb_eff = lb_legal ? lb_reg : 5'h00;
  wire logic [`PBLC_IRQ_W-1:0] irq_ev = {wrap_next, lock_fall, count_ev && !cnt_max};
  wire logic [15:0] ctrl_val = {1'b0, cnt_mode_reg, cfg_reg, lock_reg, sync_loss_reg,
                                gen_act_reg, pwr_norm_reg, 1'b0, tx_loop_reg, 1'b0,
                                lb_reg};
  wire logic [15:0] rd_mux =
    sel_ctrl ? ctrl_val :
    sel_stat ? {{(16-`PBLC_IRQ_W){1'b0}}, irq_stat_reg} :
    sel_mask ? {{(16-`PBLC_IRQ_W){1'b0}}, irq_mask_reg} : 16'h0000;

  // ----------------------------------------------------------------
  // error counter
  // ----------------------------------------------------------------
  always_comb begin
    err_cnt_next = err_cnt_reg;
    wrap_next    = 1'b0;
    if (!chk_on) begin
      err_cnt_next = '0;
    end else if (count_ev) begin
      if (!cnt_max) begin
        err_cnt_next = err_cnt_reg + 1'b1;
      end else if (cnt_mode_reg) begin
        err_cnt_next = '0;
        wrap_next    = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {lock_s1, lock_s2, gen_s1, gen_s2} <= 4'h0;
      {err_s1, err_s2}                   <= 2'h0;
      {slp_s1, slp_s2}                   <= 2'h0;
    end else begin
      lock_s1 <= i_chk_locked;
      lock_s2 <= lock_s1;
      gen_s1  <= i_gen_active;
      gen_s2  <= gen_s1;
      err_s1  <= i_chk_err;
      err_s2  <= err_s1;
      slp_s1  <= i_active_sleep;
      slp_s2  <= slp_s1;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_mode_reg <= CTRL_RST[`PBLC_BIT_CNT_MODE];
      cfg_reg      <= CTRL_RST[`PBLC_BIT_CFG_HI:`PBLC_BIT_CFG_LO];
      tx_loop_reg  <= CTRL_RST[`PBLC_BIT_TX_LOOP];
      lb_reg       <= CTRL_RST[`PBLC_BIT_LB_HI:`PBLC_BIT_LB_LO];
    end else if (wr_ctrl) begin
      cnt_mode_reg <= i_wdata[`PBLC_BIT_CNT_MODE];
      cfg_reg      <= i_wdata[`PBLC_BIT_CFG_HI:`PBLC_BIT_CFG_LO];
      tx_loop_reg  <= i_wdata[`PBLC_BIT_TX_LOOP];
      lb_reg       <= i_wdata[`PBLC_BIT_LB_HI:`PBLC_BIT_LB_LO];
    end
  end

  // ----------------------------------------------------------------
  // status, counter, interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_reg      <= 1'b0;
      sync_loss_reg <= 1'b0;
      gen_act_reg   <= 1'b0;
      pwr_norm_reg  <= CTRL_RST[`PBLC_BIT_PWR_NORM];
      err_cnt_reg   <= '0;
      irq_stat_reg  <= '0;
      irq_mask_reg  <= '0;
    end else begin
      lock_reg      <= lock_s2 && chk_on;
      sync_loss_reg <= chk_on && (sync_loss_reg || lock_fall);
      gen_act_reg   <= gen_s2 && gen_on;
      pwr_norm_reg  <= !slp_s2;
      err_cnt_reg   <= err_cnt_next;
      irq_stat_reg  <= irq_ev | (irq_stat_reg & ~(wr_stat ? i_wdata[`PBLC_IRQ_W-1:0] : '0));
      if (wr_mask) begin
        irq_mask_reg <= i_wdata[`PBLC_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata          <= 16'h0000;
      o_gen_en         <= 1'b0;
      o_gen_continuous <= 1'b0;
      o_chk_en         <= 1'b0;
      o_tx_in_loop     <= 1'b0;
      o_lb_sel         <= 5'h00;
      o_err_count      <= '0;
      o_err_wrap       <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      o_rdata          <= i_rd ? rd_mux : 16'h0000;
      o_gen_en         <= gen_on;
      o_gen_continuous <= gen_cont;
      o_chk_en         <= chk_on;
      o_tx_in_loop     <= tx_loop_reg && i_speed_100 && i_mii_loopback;
      o_lb_sel         <= lb_eff;
      o_err_count      <= err_cnt_next;
      o_err_wrap       <= wrap_next;
      o_irq            <= |((irq_ev | irq_stat_reg) & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_err_saturate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (chk_on && !cnt_mode_reg && cnt_max && !wr_ctrl) |=> cnt_max)
    else $error("error counter left maximum in single mode");
  a_err_wrap_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (chk_on && cnt_mode_reg && cnt_max && count_ev) |=> (err_cnt_reg == '0) && o_err_wrap)
    else $error("continuous counter did not wrap with pulse");
  a_cfg_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cfg_reg == 2'h0) |=> !o_gen_en && !o_chk_en)
    else $error("config zero left a function enabled");
  a_cfg_single: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cfg_reg == 2'h1) |=> o_gen_en && !o_gen_continuous && !o_chk_en)
    else $error("config one not single packet");
  a_cfg_both: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cfg_reg == 2'h3) |=> o_gen_en && o_gen_continuous && o_chk_en)
    else $error("config three not continuous both");
  a_lock_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (chk_on && lock_s2) |=> lock_reg)
    else $error("lock bit not set while locked");
  a_sync_loss_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    lock_fall |=> sync_loss_reg)
    else $error("sync loss not flagged");
  a_power_bit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    slp_s2 |=> !pwr_norm_reg)
    else $error("power bit high in active sleep");
  a_tx_loop_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_tx_in_loop |-> $past(i_speed_100) && $past(i_mii_loopback))
    else $error("transmit in loopback outside 100 Mbps loopback");
  a_lb_reserved: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !lb_legal |=> (o_lb_sel == 5'h00))
    else $error("reserved loopback select passed through");

  // ----------------------------------------------------------------
  // counter, config, status, select and interrupt checks
  // ----------------------------------------------------------------
  a_single_no_wrap: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !cnt_mode_reg |=> !o_err_wrap)
    else $error("wrap pulse in single mode");
  a_err_count_step: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (count_ev && !cnt_max) |=> (err_cnt_reg == $past(err_cnt_reg) + 1'b1))
    else $error("error counter did not advance by one");
  a_wrap_pulse_one: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_err_wrap |=> !o_err_wrap)
    else $error("wrap pulse longer than one cycle");
  a_wrap_at_max: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_err_wrap |-> $past(cnt_max) && $past(count_ev) && $past(cnt_mode_reg))
    else $error("wrap pulse without counted error at maximum");
  a_cfg_chk_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cfg_reg == 2'h2) |=> !o_gen_en && o_chk_en)
    else $error("config two not checker only");
  a_err_clear_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !chk_on |=> (err_cnt_reg == '0))
    else $error("error counter kept with checker off");
  a_gen_cont_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cfg_reg != 2'h3) |=> !o_gen_continuous)
    else $error("continuous generation outside config three");
  a_lock_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(chk_on && lock_s2) |=> !lock_reg)
    else $error("lock bit set while not locked");
  a_sync_loss_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (sync_loss_reg && chk_on) |=> sync_loss_reg)
    else $error("sync loss flag dropped while checker on");
  a_sync_loss_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !chk_on |=> !sync_loss_reg)
    else $error("sync loss flag kept with checker off");
  a_irq_sync_loss: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (irq_stat_reg[1] && irq_mask_reg[1]) |=> o_irq)
    else $error("unmasked sync loss status without interrupt");
  a_irq_masked: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (irq_mask_reg == '0) |=> !o_irq)
    else $error("interrupt raised with all sources masked");
  a_gen_status_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !gen_on |=> !gen_act_reg)
    else $error("generator status set while generator off");
  a_gen_status_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (gen_on && gen_s2) |=> gen_act_reg)
    else $error("generator status clear while active");
  a_power_normal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !slp_s2 |=> pwr_norm_reg)
    else $error("power bit low outside active sleep");
  a_tx_loop_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (tx_loop_reg && i_speed_100 && i_mii_loopback) |=> o_tx_in_loop)
    else $error("transmit in loopback not enabled");
  a_lb_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    lb_legal |=> (o_lb_sel == $past(lb_reg)))
    else $error("legal loopback select not passed through");

endmodule // pblc_ctrl

//--- pblc_regs.svh
// register offsets, field positions, reset values and counts for the self-test control block
`ifndef PBLC_REGS_SVH
`define PBLC_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PBLC_OFF_CTRL      5'h16
`define PBLC_OFF_IRQ_STAT  5'h1E
`define PBLC_OFF_IRQ_MASK  5'h1F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PBLC_BIT_CNT_MODE  14
`define PBLC_BIT_CFG_HI    13
`define PBLC_BIT_CFG_LO    12
`define PBLC_BIT_LOCK      11
`define PBLC_BIT_SYNC_LOSS 10
`define PBLC_BIT_GEN_ACT   9
`define PBLC_BIT_PWR_NORM  8
`define PBLC_BIT_TX_LOOP   6
`define PBLC_BIT_LB_HI     4
`define PBLC_BIT_LB_LO     0

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define PBLC_CTRL_RESET    16'h0100
`define PBLC_ERR_CNT_W     8
`define PBLC_IRQ_W         3

`endif

//--- pblc_pkg.sv
// types for the self-test and loopback control block
package pblc_pkg;
  typedef enum logic [1:0] {
    PBLC_CFG_OFF, PBLC_CFG_GEN_SINGLE, PBLC_CFG_CHK_ONLY, PBLC_CFG_GEN_CHK
  } pblc_cfg_t;
  typedef enum logic [4:0] {
    PBLC_LB_NONE = 5'h00, PBLC_LB_PCS_IN = 5'h01, PBLC_LB_PCS_OUT = 5'h02,
    PBLC_LB_DIGITAL = 5'h04, PBLC_LB_ANALOG = 5'h08, PBLC_LB_REVERSE = 5'h10
  } pblc_lb_t;
endpackage

//--- testbench.sv
// self-checking bench for the self-test and loopback control block
`timescale 1ns/100ps
`include "pblc_regs.svh"

`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("FAIL at %0t ns: got %h expected %h", $time, g, e); \
    end \
  end

module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        i_clk;
  logic        i_reset_n;
  logic [4:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic        i_chk_err;
  logic        i_chk_locked;
  logic        i_gen_active;
  logic        i_active_sleep;
  logic        i_speed_100;
  logic        i_mii_loopback;
  logic        o_gen_en;
  logic        o_gen_continuous;
  logic        o_chk_en;
  logic        o_tx_in_loop;
  logic [4:0]  o_lb_sel;
  logic [7:0]  o_err_count;
  logic        o_err_wrap;
  logic        o_irq;
  int          num_errors;
  int          check_count;
  int          wraps;
  logic [4:0]  lb_vals [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03, 5'h1F};

  pblc_ctrl #(.ERR_W(8)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_chk_err(i_chk_err),
    .i_chk_locked(i_chk_locked), .i_gen_active(i_gen_active),
    .i_active_sleep(i_active_sleep), .i_speed_100(i_speed_100),
    .i_mii_loopback(i_mii_loopback), .o_gen_en(o_gen_en),
    .o_gen_continuous(o_gen_continuous), .o_chk_en(o_chk_en),
    .o_tx_in_loop(o_tx_in_loop), .o_lb_sel(o_lb_sel), .o_err_count(o_err_count),
    .o_err_wrap(o_err_wrap), .o_irq(o_irq)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // counts wrap pulses of the error counter
  always @(posedge i_clk) begin
    if (o_err_wrap === 1'b1) wraps <= wraps + 1;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    `CHK(o_rdata, e)
    @(posedge i_clk);
  endtask

  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_irq !== e && n < 5) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_irq, e)
    @(posedge i_clk);
  endtask

  task automatic results;
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #500_000;
    num_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_reset_n, i_addr, i_wdata, i_wr, i_rd, i_chk_err, i_chk_locked} = '0;
    {i_gen_active, i_active_sleep, i_speed_100, i_mii_loopback, wraps} = '0;
    num_errors  = 0;
    check_count = 0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(`PBLC_OFF_CTRL, 16'h0100);
    rd(5'h05, 16'h0000);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    wr(`PBLC_OFF_CTRL, 16'hFFFF);
    rd(`PBLC_OFF_CTRL, 16'h715F);
    for (int c = 0; c < 4; c++) begin
      wr(`PBLC_OFF_CTRL, {2'b00, c[1:0], 12'h000});
      repeat (2) @(posedge i_clk);
      #1;
      `CHK(o_gen_en, c[0])
      `CHK(o_chk_en, c[1])
      `CHK(o_gen_continuous, c == 3)
    end
    for (int k = 0; k < 8; k++) begin
      wr(`PBLC_OFF_CTRL, {11'h000, lb_vals[k]});
      rd(`PBLC_OFF_CTRL, {11'h008, lb_vals[k]});
      `CHK(o_lb_sel, $onehot0(lb_vals[k]) ? lb_vals[k] : 5'h00)
    end
    for (int s = 0; s < 4; s++) begin
      i_speed_100    <= s[0];
      i_mii_loopback <= s[1];
      wr(`PBLC_OFF_CTRL, {9'h000, s[1], 6'h00});
      rd(`PBLC_OFF_CTRL, {9'h002, s[1], 6'h00});
      `CHK(o_tx_in_loop, s == 3)
    end
    // checker status, sync loss and its interrupt
    wr(`PBLC_OFF_CTRL, 16'h3000);
    i_chk_locked <= 1'b1;
    i_gen_active <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd(`PBLC_OFF_CTRL, 16'h3B00);
    i_chk_locked <= 1'b0;
    repeat (5) @(posedge i_clk);
    rd(`PBLC_OFF_CTRL, 16'h3700);
    rd(`PBLC_OFF_IRQ_STAT, 16'h0002);
    `CHK(o_irq, 1'b0)
    wr(`PBLC_OFF_IRQ_MASK, 16'h0002);
    wait_irq(1'b1);
    wr(`PBLC_OFF_IRQ_STAT, 16'h0002);
    wait_irq(1'b0);
    i_active_sleep <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd(`PBLC_OFF_CTRL, 16'h3600);
    i_active_sleep <= 1'b0;
    i_gen_active   <= 1'b0;
    wr(`PBLC_OFF_CTRL, 16'h0000);
    repeat (5) @(posedge i_clk);
    rd(`PBLC_OFF_CTRL, 16'h0100);
    // error counter: single then continuous mode
    wr(`PBLC_OFF_CTRL, 16'h2000);
    i_chk_err <= 1'b1;
    repeat (300) @(posedge i_clk);
    i_chk_err <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    `CHK(o_err_count, 8'hFF)
    `CHK(wraps, 0)
    `CHK(o_err_wrap, 1'b0)
    rd(`PBLC_OFF_IRQ_STAT, 16'h0001);
    wr(`PBLC_OFF_CTRL, 16'h0000);
    repeat (3) @(posedge i_clk);
    #1;
    `CHK(o_err_count, 8'h00)
    wr(`PBLC_OFF_CTRL, 16'h6000);
    i_chk_err <= 1'b1;
    repeat (256) @(posedge i_clk);
    i_chk_err <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    `CHK(o_err_count, 8'h00)
    `CHK(wraps, 1)
    rd(`PBLC_OFF_IRQ_STAT, 16'h0005);
    wr(`PBLC_OFF_IRQ_MASK, 16'h0005);
    wait_irq(1'b1);
    wr(`PBLC_OFF_IRQ_STAT, 16'h0007);
    wait_irq(1'b0);
    rd(`PBLC_OFF_IRQ_STAT, 16'h0000);
    results();
  end
endmodule // testbench
